// >>> verilog/sdc_regs.svh
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

// ****************************************************************
// Field widths
// ****************************************************************
`define SDC_M_W 9
`define SDC_N_W 2
`define SDC_T_W 3
`define SDC_SR_W 14

// ****************************************************************
// Shift register field positions
// ****************************************************************
`define SDC_SR_M_LSB 0
`define SDC_SR_M_MSB 8
`define SDC_SR_N_LSB 9
`define SDC_SR_N_MSB 10
`define SDC_SR_T_LSB 11
`define SDC_SR_T_MSB 13

// ****************************************************************
// Reset values
// ****************************************************************
`define SDC_M_RST 9'h1ff
`define SDC_N_RST 2'h3
`define SDC_T_RST 3'h0
`define SDC_SR_RST 14'h0000

// ****************************************************************
// Divider counts
// ****************************************************************
`define SDC_REF_DIV 16
`define SDC_REF_CW 4
`define SDC_QUART_CW 2

`endif

// >>> verilog/sdc_pkg.sv
package sdc_pkg;

`include "sdc_regs.svh"

    // ************************************************************
    // Codes
    // ************************************************************
    typedef enum logic [2:0] {
        SDC_T_SHIFT = 3'b000,
        SDC_T_HIGH = 3'b001,
        SDC_T_REF = 3'b010,
        SDC_T_FB = 3'b011,
        SDC_T_FOUT = 3'b100,
        SDC_T_LOW = 3'b101,
        SDC_T_SCAN = 3'b110,
        SDC_T_QUART = 3'b111
    } sdc_test_t;

    typedef enum logic [1:0] {
        SDC_N_BY2 = 2'b00,
        SDC_N_BY4 = 2'b01,
        SDC_N_BY8 = 2'b10,
        SDC_N_BY1 = 2'b11
    } sdc_ndiv_t;

    // ************************************************************
    // State records
    // ************************************************************
    typedef struct packed {
        logic sclk_p;
        logic shifted;
        logic [`SDC_SR_W-1:0] sr;
    } sdc_shift_state_t;

    typedef struct packed {
        logic src_p;
        logic [`SDC_REF_CW-1:0] ref_cnt;
        logic ref_clk;
        logic vco_p;
        logic vco_lvl;
        logic [`SDC_M_W-1:0] m_cnt;
        logic fb;
        logic [2:0] n_cnt;
        logic fout;
        logic fout_p;
        logic [`SDC_QUART_CW-1:0] q_cnt;
        logic quart;
    } sdc_div_state_t;

    typedef struct packed {
        logic par_p;
        logic sld_p;
        logic [`SDC_M_W-1:0] m;
        logic [`SDC_N_W-1:0] n;
        logic [`SDC_T_W-1:0] t;
        logic test;
        logic fout;
        logic fout_n;
        logic ref_clk;
        logic fb_clk;
        logic ref_p;
        logic fb_p;
        logic up;
        logic dn;
        logic osc_out;
    } sdc_top_state_t;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic sdc_rise(input logic prev, input logic cur);
        return cur & ~prev;
    endfunction

endpackage

// >>> verilog/sdc_if.sv
`timescale 1ns/1ps
interface sdc_if;
    logic [8:0] loop_div;
    logic [1:0] out_sel;
    logic scan_mode;
    logic ref_clk;
    logic fb_clk;
    logic fout;
    logic fout_q4;

    modport cfg (
        output loop_div,
        output out_sel,
        output scan_mode,
        input ref_clk,
        input fb_clk,
        input fout,
        input fout_q4
    );

    modport div (
        input loop_div,
        input out_sel,
        input scan_mode,
        output ref_clk,
        output fb_clk,
        output fout,
        output fout_q4
    );
endinterface

// >>> verilog/sdc_shift.sv
`timescale 1ns/1ps
`include "sdc_regs.svh"
module sdc_shift (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial pins
    input wire logic sclk_i,
    input wire logic sdata_i,
    // Shift contents
    output logic [`SDC_SR_W-1:0] sr_o,
    output logic shifted_o
);
    import sdc_pkg::*;

    localparam sdc_shift_state_t RST = '{
        sclk_p: 1'b0, shifted: 1'b0, sr: `SDC_SR_RST};

    sdc_shift_state_t s_q;
    sdc_shift_state_t s_d;

    // ************************************************************
    // Shift on each serial clock rise
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.sclk_p = sclk_i;
        s_d.shifted = 1'b0;
        if (sdc_rise(s_q.sclk_p, sclk_i)) begin
            s_d.sr = {s_q.sr[`SDC_SR_W-2:0], sdata_i};
            s_d.shifted = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign sr_o = s_q.sr;
    assign shifted_o = s_q.shifted;
endmodule

// >>> verilog/sdc_div.sv
`timescale 1ns/1ps
`include "sdc_regs.svh"
module sdc_div (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Clock sources and reference select, sampled as levels
    input wire logic ref_sel_i,
    input wire logic osc_i,
    input wire logic ext_ref_i,
    input wire logic vco_i,
    input wire logic sclk_i,
    // Settings and results
    sdc_if.div bus
);
    import sdc_pkg::*;

    localparam sdc_div_state_t RST = '0;

    sdc_div_state_t s_q;
    sdc_div_state_t s_d;
    logic src;
    logic csrc;
    logic [`SDC_M_W-1:0] m_last;

    // ************************************************************
    // Reference, loop and output dividers
    // ************************************************************
    always_comb begin
        s_d = s_q;
        src = ref_sel_i ? osc_i : ext_ref_i;
        csrc = bus.scan_mode ? sclk_i : vco_i;
        m_last = (bus.loop_div == '0) ? '0 :
            bus.loop_div - `SDC_M_W'(1);
        s_d.src_p = src;
        if (sdc_rise(s_q.src_p, src)) begin
            s_d.ref_cnt = s_q.ref_cnt + `SDC_REF_CW'(1);
        end
        s_d.ref_clk = s_q.ref_cnt[`SDC_REF_CW-1];
        s_d.vco_p = csrc;
        s_d.vco_lvl = csrc;
        if (sdc_rise(s_q.vco_p, csrc)) begin
            s_d.n_cnt = s_q.n_cnt + 3'h1;
            if (s_q.m_cnt >= m_last) begin
                s_d.m_cnt = '0;
                s_d.fb = ~s_q.fb;
            end else begin
                s_d.m_cnt = s_q.m_cnt + `SDC_M_W'(1);
            end
        end
        unique case (sdc_ndiv_t'(bus.out_sel))
            SDC_N_BY1: s_d.fout = s_q.vco_lvl;
            SDC_N_BY2: s_d.fout = s_q.n_cnt[0];
            SDC_N_BY4: s_d.fout = s_q.n_cnt[1];
            SDC_N_BY8: s_d.fout = s_q.n_cnt[2];
        endcase
        s_d.fout_p = s_q.fout;
        if (sdc_rise(s_q.fout_p, s_q.fout)) begin
            s_d.q_cnt = s_q.q_cnt + `SDC_QUART_CW'(1);
        end
        s_d.quart = s_q.q_cnt[`SDC_QUART_CW-1];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.ref_clk = s_q.ref_clk;
    assign bus.fb_clk = s_q.fb;
    assign bus.fout = s_q.fout;
    assign bus.fout_q4 = s_q.quart;
endmodule

// >>> verilog/sdc_top.sv
`timescale 1ns/1ps
`include "sdc_regs.svh"
module sdc_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Parallel configuration pins
    input wire logic parallel_load_strobe_n_i,
    input wire logic [8:0] loop_div_bits_i,
    input wire logic [1:0] out_div_select_i,
    input wire logic ref_source_select_i,
    // Serial configuration pins
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic serial_load_i,
    // Clock sources, sampled as levels
    input wire logic osc_in_i,
    input wire logic external_reference_in_i,
    input wire logic vco_i,
    // Clock outputs
    output logic osc_out_o,
    output logic synth_out_o,
    output logic synth_out_n_o,
    output logic test_o,
    // Loop outputs
    output logic ref_clk_o,
    output logic fb_clk_o,
    output logic pd_up_o,
    output logic pd_dn_o,
    // Active settings
    output logic [8:0] loop_div_bits_o,
    output logic [1:0] out_div_select_o,
    output logic [2:0] test_select_bits_o
);
    import sdc_pkg::*;

    localparam sdc_top_state_t RST = '{
        par_p: 1'b1, sld_p: 1'b0,
        m: `SDC_M_RST, n: `SDC_N_RST, t: `SDC_T_RST,
        test: 1'b0, fout: 1'b0, fout_n: 1'b1,
        ref_clk: 1'b0, fb_clk: 1'b0, ref_p: 1'b0, fb_p: 1'b0,
        up: 1'b0, dn: 1'b0, osc_out: 1'b0};

    sdc_top_state_t s_q;
    sdc_top_state_t s_d;
    logic [`SDC_SR_W-1:0] sr;
    logic shifted;
    logic ref_rise;
    logic fb_rise;

    sdc_if bus ();

    // ************************************************************
    // Submodules
    // ************************************************************
    sdc_shift u_shift (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sclk_i(serial_clk_i),
        .sdata_i(serial_data_i),
        .sr_o(sr),
        .shifted_o(shifted)
    );

    sdc_div u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ref_sel_i(ref_source_select_i),
        .osc_i(osc_in_i),
        .ext_ref_i(external_reference_in_i),
        .vco_i(vco_i),
        .sclk_i(serial_clk_i),
        .bus(bus)
    );

    assign bus.loop_div = s_q.m;
    assign bus.out_sel = s_q.n;
    assign bus.scan_mode = (sdc_test_t'(s_q.t) == SDC_T_SCAN);

    // ************************************************************
    // Configuration and outputs
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.par_p = parallel_load_strobe_n_i;
        s_d.sld_p = serial_load_i;
        ref_rise = sdc_rise(s_q.ref_p, bus.ref_clk);
        fb_rise = sdc_rise(s_q.fb_p, bus.fb_clk);
        if (!parallel_load_strobe_n_i) begin
            s_d.m = loop_div_bits_i;
            s_d.n = out_div_select_i;
            s_d.t = SDC_T_SHIFT;
        end else if (!s_q.par_p) begin
            s_d.m = loop_div_bits_i;
            s_d.n = out_div_select_i;
        end else if (sdc_rise(s_q.sld_p, serial_load_i)) begin
            s_d.m = sr[`SDC_SR_M_MSB:`SDC_SR_M_LSB];
            s_d.n = sr[`SDC_SR_N_MSB:`SDC_SR_N_LSB];
            s_d.t = sr[`SDC_SR_T_MSB:`SDC_SR_T_LSB];
        end else if (serial_load_i && s_q.sld_p && shifted) begin
            s_d.m = sr[`SDC_SR_M_MSB:`SDC_SR_M_LSB];
            s_d.n = sr[`SDC_SR_N_MSB:`SDC_SR_N_LSB];
            s_d.t = sr[`SDC_SR_T_MSB:`SDC_SR_T_LSB];
        end
        // Falling serial load leaves settings untouched
        unique case (sdc_test_t'(s_q.t))
            SDC_T_SHIFT: s_d.test = sr[`SDC_SR_W-1];
            SDC_T_HIGH: s_d.test = 1'b1;
            SDC_T_REF: s_d.test = bus.ref_clk;
            SDC_T_FB: s_d.test = bus.fb_clk;
            SDC_T_FOUT: s_d.test = bus.fout;
            SDC_T_LOW: s_d.test = 1'b0;
            SDC_T_SCAN: s_d.test = bus.fb_clk;
            SDC_T_QUART: s_d.test = bus.fout_q4;
        endcase
        s_d.fout = bus.fout;
        s_d.fout_n = ~bus.fout;
        s_d.ref_clk = bus.ref_clk;
        s_d.fb_clk = bus.fb_clk;
        s_d.ref_p = bus.ref_clk;
        s_d.fb_p = bus.fb_clk;
        s_d.osc_out = ~osc_in_i;
        // Phase detector, reference against feedback
        if ((s_q.up || ref_rise) && (s_q.dn || fb_rise)) begin
            s_d.up = 1'b0;
            s_d.dn = 1'b0;
        end else begin
            s_d.up = s_q.up | ref_rise;
            s_d.dn = s_q.dn | fb_rise;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign osc_out_o = s_q.osc_out;
    assign synth_out_o = s_q.fout;
    assign synth_out_n_o = s_q.fout_n;
    assign test_o = s_q.test;
    assign ref_clk_o = s_q.ref_clk;
    assign fb_clk_o = s_q.fb_clk;
    assign pd_up_o = s_q.up;
    assign pd_dn_o = s_q.dn;
    assign loop_div_bits_o = s_q.m;
    assign out_div_select_o = s_q.n;
    assign test_select_bits_o = s_q.t;
endmodule

// >>> testbench/sdc_top_properties.sv
`timescale 1ns/1ps
module sdc_top_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Configuration pins
    input wire logic parallel_load_strobe_n_i,
    input wire logic [8:0] loop_div_bits_i,
    input wire logic [1:0] out_div_select_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic serial_load_i,
    // Outputs
    input wire logic synth_out_o,
    input wire logic synth_out_n_o,
    input wire logic test_o,
    input wire logic [8:0] loop_div_bits_o,
    input wire logic [1:0] out_div_select_o,
    input wire logic [2:0] test_select_bits_o,
    // Crystal drive and phase detector
    input wire logic osc_in_i,
    input wire logic osc_out_o,
    input wire logic pd_up_o,
    input wire logic pd_dn_o
);
    // ****************
    // Shift mirror
    // ****************
    logic sp_q;
    logic [13:0] sr_q;
    logic pl;
    logic [13:0] cur;
    assign pl = parallel_load_strobe_n_i;
    assign cur = {test_select_bits_o, out_div_select_o, loop_div_bits_o};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp_q <= 1'b0;
            sr_q <= 14'h0000;
        end else begin
            sp_q <= serial_clk_i;
            if (serial_clk_i && !sp_q) begin
                sr_q <= {sr_q[12:0], serial_data_i};
            end
        end
    end
    // ****************
    // Properties
    // ****************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_par_follow: assert property (!pl |=>
        cur[10:0] == $past({out_div_select_i, loop_div_bits_i}))
        else $error("settings do not follow pins");
    a_par_capture: assert property ($rose(pl) |=>
        cur[10:0] == $past({out_div_select_i, loop_div_bits_i}))
        else $error("capture at strobe rise wrong");
    a_settings_hold: assert property ((pl && $past(pl) &&
        $past(pl, 2) && !serial_load_i && !$past(serial_load_i) &&
        !$past(serial_load_i, 2)) |=> $stable(cur))
        else $error("settings changed while held");
    a_test_par: assert property (!$past(pl) |->
        test_select_bits_o == 3'h0)
        else $error("test select not cleared in parallel mode");
    a_test_high: assert property ((test_select_bits_o == 3'h1) [*4]
        |-> test_o)
        else $error("test output not high");
    a_test_low: assert property ((test_select_bits_o == 3'h5) [*4]
        |-> !test_o)
        else $error("test output not low");
    a_reset_vals: assert property (disable iff (1'b0) rst_i |=>
        cur == 14'h07ff)
        else $error("reset values wrong");
    a_out_pair: assert property (synth_out_n_o != synth_out_o)
        else $error("output pair not complementary");
    a_load_xfer: assert property (pl && $past(pl) &&
        $rose(serial_load_i) |-> ##[1:2] cur == sr_q)
        else $error("serial transfer wrong");
    a_osc_drive: assert property (!$past(rst_i) |->
        osc_out_o == !$past(osc_in_i))
        else $error("crystal drive not inverse of input");
    a_pd_exclusive: assert property (!(pd_up_o && pd_dn_o))
        else $error("phase detector up and down together");
endmodule

bind sdc_top sdc_top_props i_props (.clk_i, .rst_i,
    .parallel_load_strobe_n_i, .loop_div_bits_i, .out_div_select_i,
    .serial_clk_i, .serial_data_i, .serial_load_i, .synth_out_o,
    .synth_out_n_o, .test_o, .loop_div_bits_o, .out_div_select_o,
    .test_select_bits_o, .osc_in_i, .osc_out_o, .pd_up_o, .pd_dn_o);

// >>> testbench/sdc_ctrl_model.sv
`timescale 1ns/1ps
module sdc_ctrl_model (
    // Clock
    input wire logic clk_i,
    // Command
    input wire logic go_i,
    input wire logic [13:0] word_i,
    // Serial pins and busy flag
    output logic sclk_o,
    output logic sdata_o,
    output logic sload_o,
    output logic busy_o
);
    // ****************
    // Frame sender
    // ****************
    logic [6:0] step;
    logic [13:0] w;
    initial begin
        {sclk_o, sdata_o, sload_o, busy_o} = 4'h0;
        step = 7'h00;
        w = 14'h0000;
    end
    always @(posedge clk_i) begin
        if (go_i && !busy_o) begin
            busy_o <= 1'b1;
            step <= 7'h00;
            w <= word_i;
        end else if (busy_o) begin
            step <= step + 7'h01;
            if (step < 7'd56) begin
                sclk_o <= step[1];
                sdata_o <= w[4'd13 - step[5:2]];
            end else begin
                sclk_o <= 1'b0;
                sdata_o <= 1'b0;
            end
            sload_o <= step >= 7'd58 && step < 7'd62;
            busy_o <= step != 7'd63;
        end
    end
endmodule

// >>> testbench/test_sdc_top.sv
`timescale 1ns/1ps
module test_sdc_top;
    import sdc_pkg::*;
    // ****************
    // Signals
    // ****************
    logic clk_i, rst_i, parallel_load_strobe_n_i, ref_source_select_i;
    logic [8:0] loop_div_bits_i, loop_div_bits_o;
    logic [1:0] out_div_select_i, out_div_select_o;
    logic [2:0] test_select_bits_o;
    logic serial_clk_i, serial_data_i, serial_load_i, go, busy;
    logic osc_in_i, external_reference_in_i, vco_i, osc_out_o;
    logic synth_out_o, synth_out_n_o, test_o, ref_clk_o, fb_clk_o;
    logic pd_up_o, pd_dn_o;
    logic [13:0] word;
    logic [7:0] tick;
    logic so_p;
    int rises = 0;
    int base;
    int mismatches, total_checks;
    int hi_tab[4] = '{8, 16, 32, 4};
    logic [13:0] w_tab[3] = '{{3'h1, 2'h1, 9'd200}, {3'h5, 2'h3, 9'd300},
        {3'h7, 2'h0, 9'd250}};
    sdc_top i_dut (.clk_i, .rst_i, .parallel_load_strobe_n_i,
        .loop_div_bits_i, .out_div_select_i, .ref_source_select_i,
        .serial_clk_i, .serial_data_i, .serial_load_i, .osc_in_i,
        .external_reference_in_i, .vco_i, .osc_out_o, .synth_out_o,
        .synth_out_n_o, .test_o, .ref_clk_o, .fb_clk_o, .pd_up_o, .pd_dn_o,
        .loop_div_bits_o, .out_div_select_o, .test_select_bits_o);
    sdc_ctrl_model i_ctrl (.clk_i, .go_i(go), .word_i(word),
        .sclk_o(serial_clk_i), .sdata_o(serial_data_i),
        .sload_o(serial_load_i), .busy_o(busy));
    // ****************
    // Tasks
    // ****************
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return synth_out_o;
            1: return ref_clk_o;
            2: return test_o;
            default: return fb_clk_o;
        endcase
    endfunction
    task automatic wait_lv(input int s, input logic v, output int n);
        n = 0;
        while (pick(s) !== v && n < 5000) begin
            @(posedge clk_i) #1;
            n++;
        end
    endtask
    task automatic meas(input int s, input int e);
        int hi;
        int lo;
        repeat (300) @(posedge clk_i);
        #1;
        wait_lv(s, 1'b0, lo);
        wait_lv(s, 1'b1, lo);
        wait_lv(s, 1'b0, hi);
        wait_lv(s, 1'b1, lo);
        chk("high time", 16'(e), 16'(hi));
        chk("low time", 16'(e), 16'(lo));
    endtask
    task automatic par_set(input logic [8:0] m, input logic [1:0] n);
        @(posedge clk_i);
        parallel_load_strobe_n_i <= 1'b0;
        loop_div_bits_i <= m;
        out_div_select_i <= n;
        repeat (3) @(posedge clk_i);
        #1;
        chk("loop setting", 16'(m), 16'(loop_div_bits_o));
        chk("out select", 16'(n), 16'(out_div_select_o));
    endtask
    task automatic ser_load(input logic [13:0] v);
        int n;
        @(posedge clk_i);
        go <= 1'b1;
        word <= v;
        @(posedge clk_i);
        go <= 1'b0;
        #1;
        n = 0;
        while (busy === 1'b1 && n < 200) begin
            @(posedge clk_i) #1;
            n++;
        end
        repeat (4) @(posedge clk_i);
        #1;
        chk("settings", 16'(v), {2'h0, test_select_bits_o,
            out_div_select_o, loop_div_bits_o});
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ****************
    // Clock, sources, watchdog
    // ****************
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        tick <= tick + 8'h01;
        osc_in_i <= tick[1];
        vco_i <= tick[2];
        external_reference_in_i <= tick[3];
    end
    always @(posedge clk_i) begin
        so_p <= synth_out_o;
        if (synth_out_o === 1'b1 && so_p === 1'b0) begin
            rises <= rises + 1;
        end
    end
    initial begin
        repeat (80000) @(posedge clk_i);
        mismatches++;
        finish_test;
    end
    // ****************
    // Tests
    // ****************
    initial begin
        {rst_i, ref_source_select_i, tick} = {2'h3, 8'h00};
        {parallel_load_strobe_n_i, go, word} = 16'h0000;
        {loop_div_bits_i, out_div_select_i} = 11'h000;
        {osc_in_i, external_reference_in_i, vco_i} = 3'h0;
        repeat (6) @(posedge clk_i);
        #1;
        chk("reset", 16'h07ff, {2'h0, test_select_bits_o, out_div_select_o,
            loop_div_bits_o});
        chk("reset outputs", 16'h0020, {8'h00, test_o, synth_out_o,
            synth_out_n_o, osc_out_o, pd_up_o, pd_dn_o, ref_clk_o,
            fb_clk_o});
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            par_set(9'(125 + i * 75), 2'(i));
            meas(0, hi_tab[i]);
        end
        par_set(9'd350, 2'h2);
        parallel_load_strobe_n_i <= 1'b1;
        @(posedge clk_i);
        loop_div_bits_i <= 9'd125;
        out_div_select_i <= 2'h0;
        repeat (3) @(posedge clk_i);
        #1;
        chk("held loop", 16'd350, 16'(loop_div_bits_o));
        meas(1, 32);
        meas(3, 2800);
        ref_source_select_i <= 1'b0;
        meas(1, 128);
        for (int i = 0; i < 3; i++) begin
            ser_load(w_tab[i]);
            if (i < 2) begin
                chk("test level", 16'(i == 0), 16'(test_o));
            end
        end
        meas(2, 32);
        ser_load({3'h2, 2'h0, 9'd250});
        meas(2, 128);
        ser_load({3'h4, 2'h1, 9'd250});
        meas(2, 16);
        ser_load({3'h3, 2'h0, 9'd125});
        meas(2, 1000);
        ser_load({3'h6, 2'h0, 9'd200});
        base = rises;
        ser_load({3'h6, 2'h0, 9'd200});
        chk("scan out rises", 16'd7, 16'(rises - base));
        par_set(9'd200, 2'h3);
        chk("test select", 16'h0000, 16'(test_select_bits_o));
        finish_test;
    end
endmodule
